/* src/sbsp_pkg.sv */
// ==========================================================================
// Shared sizes, reset values and types of the synchronous burst memory port.
// ==========================================================================
package sbsp_pkg;

    // Array geometry: 17-bit word address, 36-bit words in four lanes.
    localparam int ADDR_W = 17;
    localparam int WORDS = 131072;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int WORD_W = 36;
    localparam int LOW_W = 2;

    // Reset values of the control state.
    localparam logic [LOW_W-1:0] SBSP_IDX_RST = 2'h0;
    localparam logic [ADDR_W-3:0] SBSP_ADDR_HI_RST = 15'h0;
    localparam logic [WORD_W-1:0] SBSP_WORD_RST = 36'h0;
    localparam logic [LANES-1:0] SBSP_ALL_LANES = 4'hF;

    // Kind of access decoded from the captured pins.
    typedef enum logic [2:0] {
        SBSP_IDLE = 3'h1,
        SBSP_READ = 3'h2,
        SBSP_WRITE = 3'h4
    } sbsp_cycle_t;

    // All synchronous pins as captured at one rising clock edge.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] par;
        logic [LANES-1:0] laneN;
        logic ceN;
        logic ce2N;
        logic psN;
        logic csN;
        logic advN;
        logic gateN;
        logic gwN;
    } sbsp_pins_t;

    // Captured pins after reset: strobes, selects and writes all inactive.
    localparam sbsp_pins_t SBSP_PINS_RST = '{addr: '0, data: '0, par: '0, laneN: 4'hF, default: 1'h1};

endpackage

/* src/sbsp_count_if.sv */
`timescale 1ns/1ns
// ==========================================================================
// Link between the access decoder and the burst counter.
// ==========================================================================
interface sbsp_count_if;
    import sbsp_pkg::*;
    logic load;
    logic advance;
    logic linearOrder;
    logic [LOW_W-1:0] startLow;
    logic [LOW_W-1:0] effLow;
    modport ctrl (output load, output advance, output linearOrder, output startLow, input effLow);
    modport cnt (input load, input advance, input linearOrder, input startLow, output effLow);
endinterface

/* src/sbsp_burst_counter.sv */
`timescale 1ns/1ns
// ==========================================================================
// Two-bit burst counter producing the low address bits of each access.
// ==========================================================================
module sbsp_burst_counter (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Decoder side
    sbsp_count_if.cnt cnt
);
    import sbsp_pkg::*;

    logic [LOW_W-1:0] idx_q;
    logic [LOW_W-1:0] idx_d;
    logic [LOW_W-1:0] start_q;
    logic [LOW_W-1:0] start_d;

    // A load restarts the count, an advance steps it, otherwise the word is held as a wait.
    // The order select is used live, so a change mid-burst takes effect at once.
    always_comb begin
        start_d = cnt.load ? cnt.startLow : start_q;
        if (cnt.load) begin
            idx_d = SBSP_IDX_RST;
        end else if (cnt.advance) begin
            idx_d = idx_q + 2'h1;
        end else begin
            idx_d = idx_q;
        end
        cnt.effLow = cnt.linearOrder ? start_d + idx_d : start_d ^ idx_d;
    end

    // Counter state.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= SBSP_IDX_RST;
            start_q <= SBSP_IDX_RST;
        end else begin
            idx_q <= idx_d;
            start_q <= start_d;
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_wait_holds: assert property ((!cnt.load && !cnt.advance) ##1 (!cnt.load && !cnt.advance && $stable(cnt.linearOrder))
        |-> $stable(cnt.effLow)) else $error("Wait cycle moved the burst address.");
    chk_linear_step: assert property ((cnt.linearOrder && !cnt.load) ##1 (cnt.advance && !cnt.load && cnt.linearOrder)
        |-> cnt.effLow == 2'($past(cnt.effLow) + 2'h1)) else $error("Linear burst did not step by one.");
    chk_interleave_step: assert property ((cnt.load && !cnt.linearOrder) ##1 (cnt.advance && !cnt.load && !cnt.linearOrder)
        |-> cnt.effLow == ($past(cnt.effLow) ^ 2'h1)) else $error("Interleaved burst took a wrong second word.");

endmodule

/* src/sbsp_word_array.sv */
`timescale 1ns/1ns
// ==========================================================================
// Word array with four lane write enables; each lane is eight data bits plus parity.
// ==========================================================================
module sbsp_word_array #(
    parameter int ADDR_W = sbsp_pkg::ADDR_W,
    parameter int DEPTH = sbsp_pkg::WORDS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Write side
    input wire logic wrEnable,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [sbsp_pkg::LANES-1:0] wrLanes,
    input wire logic [sbsp_pkg::WORD_W-1:0] wrWord,
    // Read side
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [sbsp_pkg::WORD_W-1:0] rdWord
);
    import sbsp_pkg::*;

    // Storage has no reset, like the cells it stands for.
    logic [WORD_W-1:0] mem [DEPTH];

    // Write lands at the edge after capture; lane i owns data bits 8i..8i+7 and parity bit i.
    always_ff @(posedge mclk) begin
        if (wrEnable) begin
            for (int i = 0; i < LANES; i++) begin
                if (wrLanes[i]) begin
                    mem[wrAddr][i*LANE_W +: LANE_W] <= wrWord[i*LANE_W +: LANE_W];
                    mem[wrAddr][DATA_W + i] <= wrWord[DATA_W + i];
                end
            end
        end
    end

    // Flow-through read path.
    assign rdWord = mem[rdAddr];

    chk_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
        (wrEnable && wrLanes == SBSP_ALL_LANES) ##1 (rdAddr == $past(wrAddr))
        |-> rdWord == $past(wrWord)) else $error("Full word write did not reach the array.");

endmodule

/* src/sbsp_sync_burst_sram.sv */
`timescale 1ns/1ns
// Summary of operation
// - Every synchronous pin is captured in registers on the rising clock edge.
// - The array holds 131072 words of 36 bits, addressed by 17 bits.
// - A two-bit counter sequences the words of a burst.
// - During burst and wait cycles the counter supplies the two low address bits.
// - A new address and select state load only on an address strobe.
// - After a burst start, later addresses are generated inside under advance control.
// - Writes are self-timed from the captured address, data and write controls.
// - Each lane write input gates eight data bits and one parity bit.
// - Lane write inputs count only while the lane write gate is low.
// - Full word write low writes all 36 bits whatever the lane controls say.
// - With the gate low, a low lane input writes; all high means read.
// - Data and parity pins float while any qualified lane write is low.
// - Primary select enables the part and gates the processor strobe.
// - Second select must also be low for the part to be selected.
// - Output enable switches the read drivers with no clock edge.
// - Burst order select and sleep act asynchronously and are never clocked.
// - A four word burst runs two cycles, then one, one and one.
// - Data in and out share pins; each side drives only its own direction.
// - Advance low steps the counter; advance high holds the address as a wait.
// - Order select low gives linear order, high gives interleaved XOR order.
// - Processor strobe with primary select loads an address and reads, or deselects if second select is high.
// - Controller strobe selects or deselects, then reads or writes per write controls.
module sbsp_sync_burst_sram (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Address and selects
    input wire logic [sbsp_pkg::ADDR_W-1:0] wordAddressInputs,
    input wire logic chipSelectN,
    input wire logic secondSelectN,
    // Burst control
    input wire logic processorAddrStrobeN,
    input wire logic controllerAddrStrobeN,
    input wire logic burstAdvanceN,
    // Write control
    input wire logic laneOneWriteN,
    input wire logic laneTwoWriteN,
    input wire logic laneThreeWriteN,
    input wire logic laneFourWriteN,
    input wire logic laneWriteGateN,
    input wire logic fullWordWriteN,
    // Asynchronous controls
    input wire logic outputEnableN,
    input wire logic burstOrderSel,
    input wire logic sleepRequest,
    // Shared data and parity pins
    input wire logic [sbsp_pkg::DATA_W-1:0] sharedDataIn,
    output logic [sbsp_pkg::DATA_W-1:0] sharedDataOut,
    output logic sharedDataOe,
    input wire logic [sbsp_pkg::LANES-1:0] laneParityIn,
    output logic [sbsp_pkg::LANES-1:0] laneParityOut,
    output logic laneParityOe
);
    import sbsp_pkg::*;

    // ======================================================================
    // Input capture
    // ======================================================================
    sbsp_pins_t pin_q;
    sbsp_pins_t pin_d;
    logic [LANES-1:0] laneWritePinsN;

    // Lane inputs gathered so that lane i sits at bit i.
    assign laneWritePinsN = {laneFourWriteN, laneThreeWriteN, laneTwoWriteN, laneOneWriteN};

    // Every synchronous pin goes through this one register stage.
    always_comb begin
        pin_d = pin_q;
        pin_d.addr = wordAddressInputs;
        pin_d.data = sharedDataIn;
        pin_d.par = laneParityIn;
        pin_d.laneN = laneWritePinsN;
        pin_d.ceN = chipSelectN;
        pin_d.ce2N = secondSelectN;
        pin_d.psN = processorAddrStrobeN;
        pin_d.csN = controllerAddrStrobeN;
        pin_d.advN = burstAdvanceN;
        pin_d.gateN = laneWriteGateN;
        pin_d.gwN = fullWordWriteN;
    end

    // Capture registers.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= SBSP_PINS_RST;
        end else begin
            pin_q <= pin_d;
        end
    end

    // ======================================================================
    // Access decode
    // ======================================================================
    logic procLoad;
    logic ctrlLoad;
    logic loadNow;
    logic selectNow;
    logic writeReq;
    logic [LANES-1:0] laneHit;
    logic [LANES-1:0] wrLanes;
    logic active_q;
    logic active_d;
    sbsp_cycle_t cycle_q;
    sbsp_cycle_t cycle_d;
    logic [ADDR_W-3:0] addrHi_q;
    logic [ADDR_W-3:0] addrHi_d;
    logic [ADDR_W-1:0] accAddr;
    logic wrEnable;

    sbsp_count_if cntIf ();

    // Strobe decode. The processor strobe is dropped while the primary select is high,
    // so a shared strobe line cannot disturb a part that is not addressed.
    always_comb begin
        procLoad = !pin_q.psN && !pin_q.ceN;
        ctrlLoad = !pin_q.csN && !procLoad;
        loadNow = procLoad || ctrlLoad;
        selectNow = !pin_q.ceN && !pin_q.ce2N;
        laneHit = ~pin_q.laneN & {LANES{!pin_q.gateN}};
        writeReq = !pin_q.gwN || (|laneHit);
        wrLanes = !pin_q.gwN ? SBSP_ALL_LANES : laneHit;
    end

    // Selection and address hold; selects are only looked at on a load.
    always_comb begin
        active_d = loadNow ? selectNow : active_q;
        addrHi_d = loadNow ? pin_q.addr[ADDR_W-1:LOW_W] : addrHi_q;
        if (!active_d) begin
            cycle_d = SBSP_IDLE;
        end else if (writeReq && !procLoad) begin
            cycle_d = SBSP_WRITE;
        end else begin
            cycle_d = SBSP_READ;
        end
    end

    // Selection, access kind and upper address registers.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'h0;
            cycle_q <= SBSP_IDLE;
            addrHi_q <= SBSP_ADDR_HI_RST;
        end else begin
            active_q <= active_d;
            cycle_q <= cycle_d;
            addrHi_q <= addrHi_d;
        end
    end

    // ======================================================================
    // Burst counter
    // ======================================================================
    // Advance is ignored on a load cycle and while deselected; order select stays unclocked.
    always_comb begin
        cntIf.load = loadNow;
        cntIf.startLow = pin_q.addr[LOW_W-1:0];
        cntIf.advance = !pin_q.advN && !loadNow && active_q;
        cntIf.linearOrder = !burstOrderSel;
    end

    sbsp_burst_counter u_counter (
        .mclk(mclk),
        .rst_n(rst_n),
        .cnt(cntIf)
    );

    // Counter bits replace the captured low bits for every access.
    assign accAddr = {addrHi_d, cntIf.effLow};

    // ======================================================================
    // Array and read path
    // ======================================================================
    logic [WORD_W-1:0] rdWord;
    logic [WORD_W-1:0] rdData_q;
    logic [WORD_W-1:0] rdData_d;

    // Sleep blocks the write strobe directly rather than through a register,
    // so a write cannot slip through on the edge after sleep is raised.
    assign wrEnable = (cycle_d == SBSP_WRITE) && !sleepRequest;

    sbsp_word_array #(
        .ADDR_W(ADDR_W),
        .DEPTH(WORDS)
    ) u_array (
        .mclk(mclk),
        .rst_n(rst_n),
        .wrEnable(wrEnable),
        .wrAddr(accAddr),
        .wrLanes(wrLanes),
        .wrWord({pin_q.par, pin_q.data}),
        .rdAddr(accAddr),
        .rdWord(rdWord)
    );

    // Read word lands one edge after capture: two cycles for the first word of a burst,
    // one for each word after it.
    always_comb begin
        rdData_d = (cycle_d == SBSP_READ) ? rdWord : rdData_q;
    end

    // Output data register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= SBSP_WORD_RST;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    // ======================================================================
    // Pin drivers
    // ======================================================================
    logic driveOk;

    // The enable is the one output not taken from a register: output enable, sleep and
    // the lane write pins must float the pins without waiting for a clock edge.
    // The far side must still float its own drivers before a read comes back.
    always_comb begin
        driveOk = (cycle_q == SBSP_READ) && !outputEnableN && !sleepRequest;
        if (!laneWriteGateN && !(&laneWritePinsN)) begin
            driveOk = 1'h0;
        end
    end

    assign sharedDataOut = rdData_q[DATA_W-1:0];
    assign laneParityOut = rdData_q[WORD_W-1:DATA_W];
    assign sharedDataOe = driveOk;
    assign laneParityOe = driveOk;

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence seqProcStart;
        !pin_q.psN && !pin_q.ceN && !pin_q.ce2N;
    endsequence

    sequence seqBurstStep;
        !pin_q.advN && pin_q.psN && pin_q.csN;
    endsequence

    chk_proc_read: assert property (seqProcStart |=> cycle_q == SBSP_READ)
        else $error("Processor strobe did not start a read.");
    chk_proc_gated: assert property ((!pin_q.psN && pin_q.ceN && pin_q.csN) |-> !loadNow)
        else $error("Processor strobe loaded with primary select high.");
    chk_second_select: assert property ((loadNow && pin_q.ce2N) |=> cycle_q == SBSP_IDLE && !sharedDataOe)
        else $error("Part selected with second select high.");
    chk_burst_address: assert property (seqProcStart ##1 seqBurstStep
        |-> accAddr[ADDR_W-1:LOW_W] == $past(pin_q.addr[ADDR_W-1:LOW_W])
        && accAddr[LOW_W-1:0] != $past(pin_q.addr[LOW_W-1:0]))
        else $error("Burst advance produced a wrong address.");
    chk_full_write: assert property ((cycle_d == SBSP_WRITE && !pin_q.gwN && !sleepRequest)
        |-> wrEnable && wrLanes == SBSP_ALL_LANES) else $error("Full word write missed a lane.");
    chk_gate_off: assert property ((pin_q.gwN && pin_q.gateN) |-> cycle_d != SBSP_WRITE)
        else $error("Lane write taken with the gate high.");
    chk_float_write: assert property ((!laneWriteGateN && !(&laneWritePinsN)) |-> !sharedDataOe && !laneParityOe)
        else $error("Pins driven during a lane write.");
    chk_oe_float: assert property (outputEnableN |-> !sharedDataOe)
        else $error("Pins driven with output enable high.");
    chk_read_data: assert property ((cycle_d == SBSP_READ) |=> sharedDataOut == $past(rdWord[DATA_W-1:0])
        && laneParityOut == $past(rdWord[WORD_W-1:DATA_W])) else $error("Read word not presented.");

    // ======================================================================
    // Further checks
    // ======================================================================
    // A wait cycle: no strobe, advance high, part still selected.
    sequence seqWaitStep;
        pin_q.advN && pin_q.psN && pin_q.csN && active_q;
    endsequence

    // The address and data pins must reach the capture stage one edge later.
    chk_pin_capture: assert property (1'b1 |=>
        pin_q.addr == $past(wordAddressInputs) && pin_q.data == $past(sharedDataIn))
        else $error("Pins not captured at the clock edge.");

    // A processor load is never a write, whatever the write pins say.
    chk_proc_nowrite: assert property (procLoad |-> cycle_d != SBSP_WRITE)
        else $error("Processor strobe started a write.");

    // Two wait cycles in a row keep the same word unless the order select moved.
    chk_wait_address: assert property ((seqWaitStep ##1 seqWaitStep)
        |-> $stable(accAddr) || $changed(burstOrderSel))
        else $error("Wait cycle moved the access address.");

    // Sleep must stop the array write and float the pins at once.
    chk_sleep_nowrite: assert property (sleepRequest |-> !wrEnable)
        else $error("Array written while asleep.");
    chk_sleep_float: assert property (sleepRequest |-> !sharedDataOe && !laneParityOe)
        else $error("Pins driven while asleep.");

endmodule

/* test/sbsp_host_model.sv */
`timescale 1ns/1ns
// ==========================================================================
// Far-side bus master model: resolves the shared data and parity pins.
// ==========================================================================
module sbsp_host_model (
    // Clock
    input wire logic mclk,
    // Device drivers
    input wire logic [sbsp_pkg::WORD_W-1:0] devWord,
    input wire logic devOe,
    // Host drivers
    input wire logic [sbsp_pkg::WORD_W-1:0] hostWord,
    input wire logic hostOe,
    // Resolved pins
    output logic [sbsp_pkg::WORD_W-1:0] pinWord,
    output logic clash
);
    import sbsp_pkg::*;
    logic [WORD_W-1:0] lastQ = '0;
    // The host drives only while writing; an undriven bus shows a changing pattern, never stale data.
    always_comb begin
        if (hostOe) begin
            pinWord = hostWord;
        end else if (devOe) begin
            pinWord = devWord;
        end else begin
            pinWord = ~lastQ;
        end
    end
    // Remember the last level so a floating bus toggles every cycle.
    always @(posedge mclk) begin
        lastQ <= pinWord;
    end
    // Both parties driving at once is contention.
    assign clash = hostOe & devOe;
endmodule

/* test/sync_burst_sram_port_bench.sv */
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin totalChecks++; if ((got) !== (exp)) begin failCount++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
// ==========================================================================
// Self-checking bench of the synchronous burst memory port.
// ==========================================================================
module sync_burst_sram_port_bench;
    import sbsp_pkg::*;
    logic mclk, rst_n, ceN, ce2N, psN, csN, advN, gateN, gwN, oeN, order, sleep, hostOe, clash, clashSeen;
    logic ceNext, ce2Next, devOe, parOe;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanesN, devPar;
    logic [WORD_W-1:0] hostWord, pinWord, mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] devData;
    int failCount = 0;
    int totalChecks = 0;

    // ==========================================================================
    // Clock, design and far-side model
    // ==========================================================================
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    sbsp_sync_burst_sram dut (.mclk(mclk), .rst_n(rst_n), .wordAddressInputs(addr), .chipSelectN(ceN),
        .secondSelectN(ce2N), .processorAddrStrobeN(psN), .controllerAddrStrobeN(csN), .burstAdvanceN(advN),
        .laneOneWriteN(lanesN[0]), .laneTwoWriteN(lanesN[1]), .laneThreeWriteN(lanesN[2]),
        .laneFourWriteN(lanesN[3]), .laneWriteGateN(gateN), .fullWordWriteN(gwN), .outputEnableN(oeN),
        .burstOrderSel(order), .sleepRequest(sleep), .sharedDataIn(pinWord[31:0]), .sharedDataOut(devData),
        .sharedDataOe(devOe), .laneParityIn(pinWord[35:32]), .laneParityOut(devPar), .laneParityOe(parOe));
    sbsp_host_model host (.mclk(mclk), .devWord({devPar, devData}), .devOe(devOe), .hostWord(hostWord),
        .hostOe(hostOe), .pinWord(pinWord), .clash(clash));
    // Latch any contention seen at a rising edge so one short overlap is not missed.
    always @(posedge mclk) begin
        if (clash === 1'b1) begin
            clashSeen <= 1'b1;
        end
    end

    // ==========================================================================
    // Pin driving tasks
    // ==========================================================================
    // One bus cycle; the host releases output enable whenever it drives write data.
    task automatic op(input logic ps, cs, adv, gw, gate, input logic [3:0] ln, input logic [16:0] a,
                      input logic [35:0] w, input logic drive);
        @(posedge mclk);
        psN <= ps;
        csN <= cs;
        advN <= adv;
        gwN <= gw;
        gateN <= gate;
        lanesN <= ln;
        addr <= a;
        hostWord <= w;
        hostOe <= drive;
        oeN <= drive;
        ceN <= ceNext;
        ce2N <= ce2Next;
    endtask
    task automatic idle();
        op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, addr, 36'h0, 1'b0);
    endtask
    // Controller-strobe write; the model merges only the lanes that the controls select.
    task automatic wr(input logic [16:0] a, input logic [35:0] w, input logic gw, gate, input logic [3:0] ln);
        logic [35:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            if (!gw || (!gate && !ln[i])) begin
                m[8*i +: 8] = 8'hFF;
                m[32+i] = 1'b1;
            end
        end
        op(1'b1, 1'b0, 1'b1, gw, gate, ln, a, w, 1'b1);
        if (!mem.exists(a)) begin
            mem[a] = '0;
        end
        mem[a] = (mem[a] & ~m) | (w & m);
        idle();
    endtask
    // Processor-strobe read with write controls given; the answer stands two edges after the request.
    task automatic rd(input logic [16:0] a, input logic gw);
        op(1'b0, 1'b1, 1'b1, gw, 1'b1, 4'hF, a, 36'h0, 1'b0);
        idle();
        idle();
        #1;
    endtask

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic t_writes();
        wr(17'h00005, 36'hA_1234_5678, 1'b0, 1'b1, 4'h0);
        rd(17'h00005, 1'b1);
        `CHK("full write", mem[17'h00005], {devPar, devData})
        wr(17'h00006, 36'h5_CAFE_F00D, 1'b0, 1'b1, 4'hF);
        rd(17'h00006, 1'b0);
        `CHK("strobe read", mem[17'h00006], {devPar, devData})
        for (int i = 0; i < LANES; i++) begin
            wr(17'h00005, 36'h0_0000_0000 | ({4'h0, 32'hFFFF_FFFF} & 36'h3_8765_4321) | 36'h9_0000_0000,
               1'b1, 1'b0, ~(4'h1 << i));
            rd(17'h00005, 1'b1);
            `CHK("lane write", mem[17'h00005], {devPar, devData})
        end
        wr(17'h00005, 36'hF_FFFF_FFFF, 1'b1, 1'b1, 4'h0);
        rd(17'h00005, 1'b1);
        `CHK("gate high", mem[17'h00005], {devPar, devData})
        $display("test writes done");
    endtask

    task automatic t_drivers();
        rd(17'h00005, 1'b1);
        `CHK("oe on", 1'b1, devOe)
        `CHK("parity oe", devOe, parOe)
        // The lane pins are captured as a write of lane three, so the host drives the word it already holds.
        @(posedge mclk);
        gateN <= 1'b0;
        lanesN <= 4'hB;
        hostWord <= mem[17'h00005];
        hostOe <= 1'b1;
        #1;
        `CHK("float lane", 1'b0, devOe)
        @(posedge mclk);
        gateN <= 1'b1;
        lanesN <= 4'hF;
        hostOe <= 1'b0;
        oeN <= 1'b1;
        #1;
        `CHK("oe off", 1'b0, devOe)
        @(posedge mclk);
        oeN <= 1'b0;
        sleep <= 1'b1;
        #1;
        `CHK("sleep", 1'b0, devOe)
        @(posedge mclk);
        sleep <= 1'b0;
        #1;
        `CHK("wake", 1'b1, devOe)
        $display("test drivers done");
    endtask

    task automatic t_select();
        rd(17'h00005, 1'b1);
        ceNext = 1'b1;
        rd(17'h00006, 1'b1);
        `CHK("ignored strobe", mem[17'h00005], {devPar, devData})
        ceNext = 1'b0;
        ce2Next = 1'b1;
        op(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 17'h00006, 36'h0, 1'b0);
        idle();
        idle();
        #1;
        `CHK("deselect", 1'b0, devOe)
        ce2Next = 1'b0;
        rd(17'h00006, 1'b1);
        `CHK("reselect", mem[17'h00006], {devPar, devData})
        $display("test select done");
    endtask

    // Burst from low bits 01 with one wait cycle after the second word.
    task automatic chk_burst(input int k, input logic ord);
        logic [1:0] n, low;
        n = (k < 2) ? 2'(k) : 2'(k - 1);
        low = ord ? (2'h1 ^ n) : (2'h1 + n);
        #1;
        `CHK("burst word", mem[{15'h0010, low}], {devPar, devData})
    endtask
    task automatic t_burst(input logic ord);
        @(posedge mclk);
        order <= ord;
        op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 17'h00041, 36'h0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            op(1'b1, 1'b1, (i == 1 || i == 4), 1'b1, 1'b1, 4'hF, 17'h00041, 36'h0, 1'b0);
            if (i > 0) begin
                chk_burst(i - 1, ord);
            end
        end
        @(posedge mclk);
        chk_burst(4, ord);
        $display("test burst order %0d done", ord);
    endtask

    // ==========================================================================
    // Main sequence, watchdog and verdict
    // ==========================================================================
    task automatic end_sim();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        {rst_n, ceN, ce2N, order, sleep, hostOe, clashSeen, ceNext, ce2Next} = '0;
        {psN, csN, advN, gateN, gwN, oeN} = '1;
        lanesN = 4'hF;
        addr = '0;
        hostWord = '0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        `CHK("reset oe", 1'b0, devOe)
        for (int j = 0; j < 4; j++) begin
            wr(17'h00040 + 17'(j), {4'(j + 5), 32'hB0B0_0000 + 32'(j)}, 1'b0, 1'b1, 4'hF);
        end
        t_writes();
        t_drivers();
        t_select();
        t_burst(1'b0);
        t_burst(1'b1);
        `CHK("contention", 1'b0, clashSeen)
        end_sim();
    end
    initial begin
        #(100 * 2000);
        failCount++;
        end_sim();
    end
endmodule
